// File: if_clock_gen.sv
// fractional interface clock generator with programmable edges
`timescale 1ns/10ps
`default_nettype none
module if_clock_gen (
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic        run,
   input  wire logic [7:0]  source_period_setting,
   input  wire logic [15:0] if_clock_period_setting,
   input  wire logic [15:0] if_clock_rise_setting,
   input  wire logic [15:0] if_clock_fall_setting,
   output logic             if_clk_level,
   output logic             if_tick
);
   logic [16:0] phase_reg;      // accumulated time within period, in period-setting units
   logic [16:0] phase_next;
   logic [17:0] half_reg;       // half-cycle index within current period
   logic        lvl_reg;
   wire  [16:0] step      = {9'h000, source_period_setting};
   wire  [16:0] per       = {1'b0, if_clock_period_setting};
   // period ends when the next cycle would reach the setting; carry remainder
   wire         wrap      = (phase_reg + step) >= per; // R11
   // ceil(2*setting/src) half cycles compared as 2*setting <= half*src
   // index of the next cycle, so the level is right in the cycle it names
   wire  [17:0] half_next = wrap ? 18'h00000 : 18'(half_reg + 18'h00002);
   wire  [25:0] half_time = half_next * step[7:0];
   wire         rise_hit  = {9'h000, if_clock_rise_setting, 1'b0} <= half_time; // R13
   wire         fall_hit  = {9'h000, if_clock_fall_setting, 1'b0} <= half_time; // R12

   // remainder carry keeps the long-run average exact
   assign phase_next = wrap ? 17'(phase_reg + step - per) : 17'(phase_reg + step); // R11

   // phase accumulator and half-cycle count
   always_ff @(posedge ref_clk) begin
      if (rst || !run) begin
         phase_reg <= 17'h00000;
         half_reg  <= 18'h00000;
      end else begin
         phase_reg <= phase_next;
         half_reg  <= half_next;
      end
   end

   // edges only land on source cycles, so odd half cycles round up to the next edge
   always_ff @(posedge ref_clk) begin
      if (rst || !run) begin
         lvl_reg <= 1'b0;
      end else begin
         // high from the rising point up to the falling point of each period
         lvl_reg <= rise_hit & ~fall_hit; // R12 R13
      end
   end

   assign if_clk_level = lvl_reg;
   assign if_tick      = run & wrap;
endmodule
`default_nettype wire

// File: panel_model.sv
// passive panel model, measures timing in source clock cycles
`timescale 1ns/10ps
`default_nettype none
module panel_model (
   input wire logic ref_clk,
   input wire logic panel_clk,
   input wire logic hsync,
   input wire logic vsync,
   input wire logic data_enable,
   input wire logic line_start_pulse,
   input wire logic reversal,
   output int       m [14]
);
   // edge times and per frame counts
   int   t, ths, tvs, tde, tc1, tc2, tsp, ndf, nrv;
   logic h0, v0, d0, c0, s0, r0, seen;
   // panel reads the active low signals as sampled on each source edge
   always @(posedge ref_clk) begin
      t = t + 1;
      if (h0 && !hsync) begin
         m[0] = t - ths;
         ths = t;
      end
      if (!h0 && hsync) m[1] = t - ths;
      // frame start latches counts of the frame just ended
      if (v0 && !vsync) begin
         m[2] = t - tvs;
         tvs = t;
         m[7] = ndf;
         m[12] = nrv;
         ndf = 0;
         nrv = 0;
         seen = 1'b0;
      end
      if (!v0 && vsync) m[3] = t - tvs;
      if (d0 && !data_enable) begin
         m[4] = t - ths;
         tde = t;
         ndf++;
         m[10] = line_start_pulse;
         if (!seen) m[6] = t - tvs;
         seen = 1'b1;
      end
      if (!d0 && data_enable) m[5] = t - tde;
      // two periods summed, since fractional periods alternate
      if (!c0 && panel_clk) begin
         m[8] = t - tc2;
         tc2 = tc1;
         tc1 = t;
      end
      if (c0 && !panel_clk) m[9] = t - tc1;
      if (s0 && !line_start_pulse) tsp = t;
      if (!s0 && line_start_pulse) m[11] = t - tsp;
      if (r0 !== reversal) nrv++;
      {h0, v0, d0, c0, s0, r0} = {hsync, vsync, data_enable, panel_clk, line_start_pulse, reversal};
   end
endmodule
`default_nettype wire

// File: panel_sync_checker_properties.sv
// port checker for the panel sync timing generator
`timescale 1ns/10ps
`default_nettype none
module panel_sync_checker (
   input wire logic        ref_clk,
   input wire logic        rst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        panel_clk,
   input wire logic        hsync,
   input wire logic        vsync,
   input wire logic        data_enable,
   input wire logic        line_start_pulse,
   input wire logic        reversal
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   // access phase of an apb transfer
   wire acc = psel && penable;
   // zero wait slave, so the access never stalls
   property p_no_wait; acc |-> pready; endproperty
   a_no_wait: assert property (p_no_wait) else $error("pready low in access");
   property p_err_in_acc; pslverr |-> acc; endproperty
   a_err_in_acc: assert property (p_err_in_acc) else $error("pslverr outside access");
   property p_err_unmapped; acc && paddr > 8'h28 |-> pslverr; endproperty
   a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped not refused");
   property p_err_unaligned; acc && paddr[1:0] != 2'h0 |-> pslverr; endproperty
   a_err_unaligned: assert property (p_err_unaligned) else $error("unaligned not refused");
   property p_ok_mapped; acc && paddr <= 8'h28 && paddr[1:0] == 2'h0 |-> !pslverr; endproperty
   a_ok_mapped: assert property (p_ok_mapped) else $error("mapped access refused");
   property p_err_rd_zero; acc && !pwrite && pslverr |-> prdata == 32'h0; endproperty
   a_err_rd_zero: assert property (p_err_rd_zero) else $error("refused read not zero");
   // set once reset has been sampled high, so outputs have seen a reset edge
   logic rst_seen_reg;
   always_ff @(posedge ref_clk) rst_seen_reg <= rst;
   // idle levels of an active low panel while reset is held
   property p_reset_idle; disable iff (1'b0) rst && rst_seen_reg |->
      !panel_clk && hsync && vsync && data_enable && line_start_pulse && !reversal; endproperty
   a_reset_idle: assert property (p_reset_idle) else $error("panel idle wrong");
   // pulse start must coincide with first data; assumes equal spl and de polarity
   property p_spl_with_de;
      $changed(line_start_pulse) && line_start_pulse == data_enable |-> $changed(data_enable);
   endproperty
   a_spl_with_de: assert property (p_spl_with_de) else $error("spl not at data");
endmodule
bind panel_sync_timing_generator panel_sync_checker chk (
   .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .panel_clk(panel_clk), .hsync(hsync), .vsync(vsync), .data_enable(data_enable),
   .line_start_pulse(line_start_pulse), .reversal(reversal));
`default_nettype wire

// File: panel_sync_timing_generator.sv
// panel sync timing generator with apb register file
`timescale 1ns/10ps
`default_nettype none
module panel_sync_timing_generator (
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             panel_clk,
   output logic             hsync,
   output logic             vsync,
   output logic             data_enable,
   output logic             line_start_pulse,
   output logic             reversal
);
   import sync_timing_pkg::*;

   // how the block works, in short
   // software programs every setting
   // while the enable bit is low,
   // then sets enable to start timing
   // all counters hold at zero when off,
   // so a restart always begins a frame
   // at line zero, pixel zero
   // clock chain, from fast to slow
   // the source clock is ref_clk itself
   // the interface clock is made from it
   // by a phase accumulator in the
   // helper module below
   // each source cycle adds the source
   // period setting to the phase
   // a period ends when the next step
   // would reach the interface period
   // setting; the remainder is kept
   // keeping the remainder makes the
   // average period exact, at the cost
   // of periods that differ by one cycle
   // rise and fall points are counted
   // in half source cycles and rounded up,
   // since edges can only land on ref_clk
   // a pixel is divider plus one
   // interface clock periods
   // a line is line count plus one pixels
   // a frame is frame count plus one lines
   // horizontal timing
   // hsync starts at the offset pixel and
   // lasts its length plus one pixels
   // the active window starts at start x;
   // pixels before it are the first blank
   // the width setting is taken as a
   // count minus one, so the window spans
   // setting plus one pixels
   // what is left of the line after the
   // window is the second blank
   // vertical timing
   // vsync starts with line zero
   // in line units it covers lines
   // zero to its length, inclusive
   // in pixel units it counts its length
   // plus one pixels from frame start,
   // and may then end in mid-line
   // the active lines start at start y
   // and span height setting plus one
   // lines; the remainder is blank two
   // reflective panel extras
   // a line start pulse of fixed width
   // marks the first data pixel of each
   // line that carries data; blank lines
   // get none, since they have no data
   // the reversal level flips at each
   // line end, once per hsync period
   // polarity
   // all pins but clock and reversal are active low
   // in their nominal form; one bit per
   // signal in the control register
   // turns that signal over
   // the inversion sits before the output
   // flops, and after the reversal flop;
   // the flops load while timing is off,
   // so a polarity change still shows
   // outputs are registered, so panel
   // pins trail the counters by one
   // ref_clk; all pins but reversal trail
   // equally, so their relative timing is kept
   // the reversal level comes straight
   // from its flop and is not delayed
   // register access
   // a zero wait apb slave: pready is
   // tied high and writes land at the
   // access edge
   // unaligned or unmapped addresses
   // answer with pslverr, writes to them
   // are dropped and reads return zero
   // the status word is read only
   // and shows the live scan position
   // limitations
   // settings are not checked against
   // each other; a window that runs past
   // the line end simply wraps never
   // counters are twelve bits wide,
   // which bounds every count setting
   // changing settings while enabled
   // may give one malformed line or
   // frame, so software should disable
   // the block before reprogramming
   // the interface period setting must
   // not be below the source period
   // setting, or every cycle ends a
   // period and the ratio is lost
   // a zero source period stalls the
   // phase and gives no interface clock
   // reset
   // reset is synchronous, active high
   // all settings return to their reset
   // values and every output goes idle
   // idle is the inactive level of each
   // pin, with the panel clock low
   // design notes
   // decoding is kept in named wires so
   // the clocked processes stay short
   // comparisons use thirteen bits where
   // a sum of two settings could carry
   // the pixel, line and frame ends are
   // chained so that one pixel tick can
   // close a line and a frame together
   // the pixel-unit vsync counter stops
   // once its pulse is over, so it
   // cannot wrap and restart mid-frame
   // the line start pulse and the data
   // window share the same start compare,
   // so they always begin together
   // the reversal flop only moves in
   // reflective mode, so a plain panel
   // sees a steady level on that pin

   // software registers
   logic [31:0] ctrl_reg;       // enable, reflective, vsync unit, polarity
   logic [31:0] if_clk_reg;     // [7:0] source period, [31:16] if period
   logic [31:0] if_edge_reg;    // [15:0] rise, [31:16] fall
   logic [31:0] pix_div_reg;    // [11:0] pixel clock divider
   logic [31:0] h_total_reg;    // [11:0] line period count
   logic [31:0] h_sync_reg;     // [11:0] pulse length, [27:16] offset
   logic [31:0] h_active_reg;   // [11:0] start x, [27:16] width
   logic [31:0] v_total_reg;    // [11:0] frame line count
   logic [31:0] v_sync_reg;     // [11:0] pulse length
   logic [31:0] v_active_reg;   // [11:0] start y, [27:16] height

   // decoded fields
   wire         run            = ctrl_reg[enable_bit];
   wire         reflective     = ctrl_reg[reflective_bit];
   wire         vsync_unit     = ctrl_reg[vsync_unit_bit];
   wire  [5:0]  signal_polarity_config = ctrl_reg[pol_lsb +: pol_width];
   wire  [11:0] pixel_clock_divider    = pix_div_reg[11:0];
   wire  [11:0] line_count     = h_total_reg[11:0];
   wire  [11:0] hs_len         = h_sync_reg[11:0];
   wire  [11:0] hs_ofs         = h_sync_reg[27:16];
   wire  [11:0] active_start_x = h_active_reg[11:0];
   wire  [11:0] active_width_setting  = h_active_reg[27:16];
   wire  [11:0] frame_count    = v_total_reg[11:0];
   wire  [11:0] vs_len         = v_sync_reg[11:0];
   wire  [11:0] active_start_y = v_active_reg[11:0];
   wire  [11:0] active_height_setting = v_active_reg[27:16];

   // apb decode; zero wait state, unmapped reads return zero with slverr
   wire         apb_acc   = psel & penable;
   wire         apb_wr    = apb_acc & pwrite;
   wire         hit_known = (paddr[1:0] == 2'b00) && (paddr <= status_off);

   // interface clock from the fast source clock
   logic        if_level;
   logic        if_tick;
   if_clock_gen u_if_clk (
      .ref_clk                 (ref_clk),
      .rst                     (rst),
      .run                     (run),
      .source_period_setting   (if_clk_reg[7:0]),
      .if_clock_period_setting (if_clk_reg[31:16]),
      .if_clock_rise_setting   (if_edge_reg[15:0]),
      .if_clock_fall_setting   (if_edge_reg[31:16]),
      .if_clk_level            (if_level),
      .if_tick                 (if_tick)
   );

   // timing state
   logic [11:0] div_reg;        // interface clocks inside one pixel
   logic [11:0] h_reg;          // pixel index in line
   logic [11:0] v_reg;          // line index in frame
   logic [11:0] vs_pix_reg;     // pixel count of a pixel-unit vsync
   logic        vs_pix_on_reg;
   logic        rev_reg;        // reversal level
   logic        hs_o_reg;
   logic        vs_o_reg;
   logic        de_o_reg;
   logic        spl_o_reg;
   logic        clk_o_reg;

   // a pixel ends on the divider+1'th interface clock
   wire         pix_tick  = if_tick && (div_reg == pixel_clock_divider); // R1
   wire         line_end  = pix_tick && (h_reg == line_count); // R2
   wire         frame_end = line_end && (v_reg == frame_count); // R7

   // horizontal windows, 13 bits so sums cannot wrap
   wire  [12:0] hs_end    = 13'(hs_ofs) + 13'(hs_len); // R3
   wire         hs_act    = (h_reg >= hs_ofs) && (13'(h_reg) <= hs_end); // R6
   wire  [12:0] hx_end    = 13'(active_start_x) + 13'(active_width_setting);
   // blank 1 is start x pixels; blank 2 is whatever remains of the line
   wire         h_act     = (h_reg >= active_start_x) && (13'(h_reg) <= hx_end); // R4 R5
   wire  [12:0] vy_end    = 13'(active_start_y) + 13'(active_height_setting);
   wire         v_act     = (v_reg >= active_start_y) && (13'(v_reg) <= vy_end); // R9 R10
   // line-unit vsync covers lines 0..len
   wire         vs_line   = (v_reg <= vs_len); // R8
   wire         vs_act    = vsync_unit ? vs_line : vs_pix_on_reg; // R8
   // fixed width pulse starting on first active pixel
   wire         spl_act   = reflective && v_act && (h_reg >= active_start_x)
                            && (13'(h_reg) < 13'(active_start_x) + 13'(spl_width)); // R14

   // interface clock divider inside a pixel
   always_ff @(posedge ref_clk) begin
      if (rst || !run) begin
         div_reg <= 12'h000;
      end else if (if_tick) begin
         div_reg <= pix_tick ? 12'h000 : 12'(div_reg + 12'h001); // R1
      end
   end

   // horizontal and vertical counters
   always_ff @(posedge ref_clk) begin
      if (rst || !run) begin
         h_reg <= 12'h000;
         v_reg <= 12'h000;
      end else if (pix_tick) begin
         h_reg <= line_end ? 12'h000 : 12'(h_reg + 12'h001); // R17
         if (line_end) begin
            v_reg <= frame_end ? 12'h000 : 12'(v_reg + 12'h001); // R17
         end
      end
   end

   // pixel-unit vsync: starts at frame start, lasts len+1 pixels
   always_ff @(posedge ref_clk) begin
      if (rst || !run) begin
         vs_pix_reg    <= 12'h000;
         vs_pix_on_reg <= 1'b1;
      end else if (frame_end) begin
         vs_pix_reg    <= 12'h000;
         vs_pix_on_reg <= 1'b1;
      end else if (pix_tick && vs_pix_on_reg) begin
         vs_pix_reg    <= 12'(vs_pix_reg + 12'h001);
         vs_pix_on_reg <= (vs_pix_reg != vs_len); // R8
      end
   end

   // reversal flips once per line, at hsync rhythm
   always_ff @(posedge ref_clk) begin
      if (rst || !run) begin
         rev_reg <= 1'b0;
      end else if (line_end && reflective) begin
         rev_reg <= ~rev_reg; // R15
      end
   end

   // registered panel outputs; nominal level is active low but the clock follows if_level, polarity bit inverts
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         clk_o_reg <= 1'b0;
         hs_o_reg  <= 1'b1;
         vs_o_reg  <= 1'b1;
         de_o_reg  <= 1'b1;
         spl_o_reg <= 1'b1;
      end else begin
         clk_o_reg <= if_level ^ signal_polarity_config[pol_clk]; // R16
         hs_o_reg  <= ~(run & hs_act) ^ signal_polarity_config[pol_hs]; // R16
         vs_o_reg  <= ~(run & vs_act) ^ signal_polarity_config[pol_vs]; // R16
         de_o_reg  <= ~(run & h_act & v_act) ^ signal_polarity_config[pol_de]; // R16
         spl_o_reg <= ~(run & spl_act) ^ signal_polarity_config[pol_spl]; // R14 R16
      end
   end

   // register writes; only fields that exist are kept
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ctrl_reg     <= ctrl_rst;
         if_clk_reg   <= if_clk_rst;
         if_edge_reg  <= if_edge_rst;
         pix_div_reg  <= zero_rst;
         h_total_reg  <= zero_rst;
         h_sync_reg   <= zero_rst;
         h_active_reg <= zero_rst;
         v_total_reg  <= zero_rst;
         v_sync_reg   <= zero_rst;
         v_active_reg <= zero_rst;
      end else if (apb_wr) begin
         unique case (paddr)
            ctrl_off:     ctrl_reg     <= {22'h000000, pwdata[9:0] & 10'h3f7};
            if_clk_off:   if_clk_reg   <= {pwdata[31:16], 8'h00, pwdata[7:0]};
            if_edge_off:  if_edge_reg  <= pwdata;
            pix_div_off:  pix_div_reg  <= {20'h00000, pwdata[11:0]};
            h_total_off:  h_total_reg  <= {20'h00000, pwdata[11:0]};
            h_sync_off:   h_sync_reg   <= {4'h0, pwdata[27:16], 4'h0, pwdata[11:0]};
            h_active_off: h_active_reg <= {4'h0, pwdata[27:16], 4'h0, pwdata[11:0]};
            v_total_off:  v_total_reg  <= {20'h00000, pwdata[11:0]};
            v_sync_off:   v_sync_reg   <= {20'h00000, pwdata[11:0]};
            v_active_off: v_active_reg <= {4'h0, pwdata[27:16], 4'h0, pwdata[11:0]};
            default: ;    // status and unmapped writes ignored
         endcase
      end
   end

   // status shows live counters so software can track scan position
   wire  [31:0] status_val = {3'h0, rev_reg, v_reg, 4'h0, h_reg};

   // read mux, combinational but sampled only at the access edge
   always_comb begin
      unique case (paddr)
         ctrl_off:     prdata = ctrl_reg;
         if_clk_off:   prdata = if_clk_reg;
         if_edge_off:  prdata = if_edge_reg;
         pix_div_off:  prdata = pix_div_reg;
         h_total_off:  prdata = h_total_reg;
         h_sync_off:   prdata = h_sync_reg;
         h_active_off: prdata = h_active_reg;
         v_total_off:  prdata = v_total_reg;
         v_sync_off:   prdata = v_sync_reg;
         v_active_off: prdata = v_active_reg;
         status_off:   prdata = status_val;
         default:      prdata = 32'h0000_0000;
      endcase
   end

   assign pready           = 1'b1;
   assign pslverr          = apb_acc & ~hit_known;
   assign panel_clk        = clk_o_reg;
   assign hsync            = hs_o_reg;
   assign vsync            = vs_o_reg;
   assign data_enable      = de_o_reg;
   assign line_start_pulse = spl_o_reg;
   assign reversal         = rev_reg ^ signal_polarity_config[pol_rev]; // R15 R16
endmodule
`default_nettype wire

// File: panel_sync_timing_generator_tb_top.sv
// self-checking bench for the panel sync timing generator
`timescale 1ns/10ps
`default_nettype none
module panel_sync_timing_generator_tb_top;
   import sync_timing_pkg::*;
   logic        ref_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr, panel_clk, hsync, vsync, data_enable, line_start_pulse;
   logic        reversal, err;
   int          m [14];
   int          n_mismatch = 0, check_count = 0, cycles = 0;
   always #2 ref_clk = ~ref_clk;
   panel_sync_timing_generator dut (.ref_clk(ref_clk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .panel_clk(panel_clk), .hsync(hsync),
      .vsync(vsync), .data_enable(data_enable), .line_start_pulse(line_start_pulse),
      .reversal(reversal));
   panel_model model (.ref_clk(ref_clk), .panel_clk(panel_clk), .hsync(hsync), .vsync(vsync),
      .data_enable(data_enable), .line_start_pulse(line_start_pulse), .reversal(reversal), .m(m));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one apb transfer, held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) n_mismatch++;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic e);
      apb(1'b0, a, 32'h0);
      check(rd, exp);
      check(err, e);
   endtask
   // timing is reprogrammed only while disabled
   task automatic cfg(input logic [31:0] c, ic, ed, dv, hs, vs);
      apb(1'b1, ctrl_off, 32'h0);
      apb(1'b1, if_clk_off, ic);
      apb(1'b1, if_edge_off, ed);
      apb(1'b1, pix_div_off, dv);
      apb(1'b1, h_total_off, 32'h9);
      apb(1'b1, h_sync_off, hs);
      apb(1'b1, h_active_off, 32'h0003_0002);
      apb(1'b1, v_total_off, 32'h5);
      apb(1'b1, v_sync_off, vs);
      apb(1'b1, v_active_off, 32'h0002_0001);
      apb(1'b1, ctrl_off, c);
   endtask
   task automatic summarize();
      if (n_mismatch == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // hang guard, run needs under two thousand cycles
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 6000) begin
         n_mismatch++;
         summarize();
      end
   end
   initial begin
      repeat (12) @(posedge ref_clk);
      rst <= 1'b0;
      rchk(ctrl_off, ctrl_rst, 1'b0);
      rchk(if_clk_off, if_clk_rst, 1'b0);
      rchk(if_edge_off, if_edge_rst, 1'b0);
      rchk(pix_div_off, zero_rst, 1'b0);
      apb(1'b1, status_off, 32'hffff_ffff);
      rchk(status_off, zero_rst, 1'b0);
      rchk(8'h2c, 32'h0, 1'b1);
      apb(1'b1, 8'h06, 32'h1);
      check(err, 1'b1);
      check({panel_clk, hsync, vsync, data_enable, line_start_pulse}, 5'h0f);
      // pixel of four cycles, reflective mode, vsync counted in lines
      cfg(32'h7, 32'h0002_0001, 32'h0001_0000, 32'h1, 32'h0000_0001, 32'h0);
      rchk(h_total_off, 32'h9, 1'b0);
      repeat (800) @(posedge ref_clk);
      check(m[0], 40);
      check(m[1], 8);
      check(m[2], 240);
      check(m[3], 40);
      check(m[4], 8);
      check(m[0] - m[4] - m[5], 16);
      check(m[6], 48);
      check(m[7], 3);
      check(m[8], 4);
      check(m[9], 1);
      check(m[10], 0);
      check(m[11], 4);
      check(m[12], 6);
      // fractional interface clock of two and a half cycles, vsync in pixels
      cfg(32'h1, 32'h0005_0002, 32'h0004_0002, 32'h0, 32'h0002_0001, 32'h3);
      repeat (500) @(posedge ref_clk);
      check(m[0], 25);
      check(m[1], 5);
      check(m[2], 150);
      check(m[3], 10);
      check(m[4], 0);
      check(m[6], 30);
      check(m[8], 5);
      check(m[9], 1);
      // every polarity bit set while disabled flips the idle levels
      cfg(32'h3f0, 32'h0002_0001, 32'h0001_0000, 32'h1, 32'h1, 32'h0);
      repeat (4) @(posedge ref_clk);
      check({panel_clk, hsync, vsync, data_enable, line_start_pulse}, 5'h10);
      check(reversal, 1'b1);
      summarize();
   end
endmodule
`default_nettype wire

// File: sync_timing_pkg.sv
// constants and register map for the panel sync timing generator
//Function
//R1: pixel clock period is (divider+1) interface clocks
//R2: line lasts line period count plus one
//R3: hsync lasts pulse length plus one pixels
//R4: first horizontal blank equals active start x
//R5: second horizontal blank is remaining line pixels
//R6: hsync delayed by programmed offset pixels
//R7: frame lasts frame line count plus one
//R8: vsync length plus one, pixels or lines
//R9: first vertical blank equals active start y
//R10: second vertical blank is remaining frame lines
//R11: interface period averages period ratio, fractional dither
//R12: falling point at ceil of twice fall
//R13: rising point at ceil of twice rise
//R14: reflective mode line start pulse at data
//R15: reflective mode reversal toggles every hsync
//R16: software inverts each panel signal polarity
//R17: counters wrap per line and per frame
package sync_timing_pkg;
   // apb register byte offsets
   localparam logic [7:0] ctrl_off       = 8'h00;
   localparam logic [7:0] if_clk_off     = 8'h04;
   localparam logic [7:0] if_edge_off    = 8'h08;
   localparam logic [7:0] pix_div_off    = 8'h0c;
   localparam logic [7:0] h_total_off    = 8'h10;
   localparam logic [7:0] h_sync_off     = 8'h14;
   localparam logic [7:0] h_active_off   = 8'h18;
   localparam logic [7:0] v_total_off    = 8'h1c;
   localparam logic [7:0] v_sync_off     = 8'h20;
   localparam logic [7:0] v_active_off   = 8'h24;
   localparam logic [7:0] status_off     = 8'h28;
   // ctrl field positions
   localparam int enable_bit      = 0;
   localparam int reflective_bit  = 1;
   localparam int vsync_unit_bit  = 2;
   localparam int pol_lsb         = 4;
   localparam int pol_width       = 6;
   // polarity bit order inside the polarity field
   localparam int pol_clk   = 0;
   localparam int pol_hs    = 1;
   localparam int pol_vs    = 2;
   localparam int pol_de    = 3;
   localparam int pol_spl   = 4;
   localparam int pol_rev   = 5;
   // reset values
   localparam logic [31:0] ctrl_rst     = 32'h0000_0000;
   localparam logic [31:0] if_clk_rst   = 32'h0001_0001;
   localparam logic [31:0] if_edge_rst  = 32'h0001_0000;
   localparam logic [31:0] zero_rst     = 32'h0000_0000;
   // fixed line start pulse width in pixel clocks
   localparam logic [11:0] spl_width    = 12'h001;
endpackage
